/* logic/ssm_pkg.sv */
// Purpose: shared constants and types of the scripted spi master
// Assumes: core clock of 100 MHz
// Notes:   timing figures in microseconds, cycle counts derived
package ssm_pkg;
    localparam real CLK_MHZ     = 100.0;
    localparam real T1_FAST_US  = 2.2;
    localparam real T1_SLOW_US  = 5.0;
    localparam real T4_FAST_US  = 2.2;
    localparam real T4_SLOW_US  = 7.4;
    localparam real T2_MIN_FAST_US = 0.02;
    localparam real T2_MIN_SLOW_US = 0.08333;
    localparam real T2_MAX_SLOW_US = 20.83;
    localparam int  T2_MAX_FAST_US = 1000;
    // least waits round up, longest periods round down
    localparam int T1_FAST = int'($ceil(T1_FAST_US * CLK_MHZ));
    localparam int T1_SLOW = int'($ceil(T1_SLOW_US * CLK_MHZ));
    localparam int T4_FAST = int'($ceil(T4_FAST_US * CLK_MHZ));
    localparam int T4_SLOW = int'($ceil(T4_SLOW_US * CLK_MHZ));
    localparam int P_MIN_FAST = int'($ceil(T2_MIN_FAST_US * CLK_MHZ));
    localparam int P_MIN_SLOW = int'($ceil(T2_MIN_SLOW_US * CLK_MHZ));
    localparam int P_MAX_SLOW = int'($floor(T2_MAX_SLOW_US * CLK_MHZ));
    localparam int P_MAX_FAST = T2_MAX_FAST_US * 100;
    // script and result sizes
    localparam int SCR_DEPTH = 64;
    localparam int RES_MAX   = 64;
    localparam int SMP_DEPTH = 256;
    localparam int SMP_W     = 16;
    localparam logic [4:0] BITS_RST = 5'h08;
    localparam logic [15:0] HALF_RST = 16'h0032;
    typedef enum logic [3:0] {
        OP_NOP   = 4'h0, OP_ENABLE = 4'h1, OP_DISABLE = 4'h2,
        OP_MODE  = 4'h3, OP_RATE   = 4'h4, OP_BITS    = 4'h5,
        OP_CSLO  = 4'h6, OP_CSHI   = 4'h7, OP_XFER    = 4'h8,
        OP_DELAY = 4'h9, OP_AUXP   = 4'hA, OP_AUXL    = 4'hB,
        OP_BASIC = 4'hC
    } ssm_op_type;
    typedef struct packed {
        ssm_op_type  op;
        logic [15:0] arg;
    } ssm_cmd_type;
    // gray codes along fetch, exec, lead, load, shift, trail
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_EXEC = 3'h3,
        ST_LEAD = 3'h2, ST_LOAD = 3'h6, ST_SHIFT = 3'h7,
        ST_TRAIL = 3'h5, ST_WAIT = 3'h4
    } ssm_st_type;
    typedef struct packed {
        ssm_st_type       st;
        ssm_cmd_type      cur;
        logic [6:0]       pc;
        logic [6:0]       len;
        logic             en;
        logic             cpol;
        logic             cpha;
        logic [15:0]      half;
        logic [4:0]       bits;
        logic [7:0]       cs;
        logic [2:0]       csSel;
        logic             sclk;
        logic             mosi;
        logic [16:0]      cnt;
        logic [4:0]       bitCnt;
        logic [7:0]       remain;
        logic [15:0]      txSh;
        logic [15:0]      rxSh;
        logic [6:0]       resCnt;
        logic [7:0]       smpPtr;
        logic             basic;
        logic             overflow;
        logic             busy;
        logic             done;
        logic             cmdReady;
        logic             txReady;
        logic [1:0][15:0] buffer;
        logic             wp;
        logic             rp;
        logic [1:0]       bcnt;
        logic             miso1;
        logic             miso2;
        logic [7:0]       aux1;
        logic [7:0]       aux2;
        logic [15:0]      rdData;
    } ssm_state_type;
endpackage

/* logic/ssm_sequencer.sv */
// Purpose: spi master that runs a queued script of commands
// Assumes: one spi port, eight chip selects, eight aux lines
// Notes:   results read back by index and offset after a run
`timescale 1ns/1ps
`default_nettype none
module ssm_sequencer #(
    parameter int MAX_PERIOD_FAST = ssm_pkg::P_MAX_FAST
) (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               slowVariant,
    input  wire logic               cmdValid,
    input  wire ssm_pkg::ssm_cmd_type cmdData,
    output logic                    cmdReady,
    input  wire logic               clearReq,
    input  wire logic               runReq,
    output logic                    busy,
    output logic                    done,
    output logic                    overflow,
    output logic [6:0]              resCount,
    input  wire logic               txValid,
    input  wire logic [15:0]        txData,
    output logic                    txReady,
    input  wire logic [5:0]         readIdx,
    input  wire logic [7:0]         readOfs,
    output logic [15:0]             rdData,
    output logic                    sclkO,
    output logic                    sclkOe,
    output logic                    mosiO,
    output logic                    mosiOe,
    input  wire logic               misoI,
    output logic [7:0]              csO,
    output logic                    csOe,
    input  wire logic [7:0]         auxIn
);
    ssm_pkg::ssm_state_type s;
    ssm_pkg::ssm_state_type n;
    ssm_pkg::ssm_cmd_type   scriptMem [ssm_pkg::SCR_DEPTH];
    logic [15:0]            sampleMem [ssm_pkg::SMP_DEPTH];
    logic [7:0]             idxTbl    [ssm_pkg::RES_MAX];
    logic        scrWe;
    logic        smpWe;
    logic        idxWe;
    logic [15:0] smpIn;
    logic        push;
    logic        pop;
    logic        leading;
    logic        smpEdge;
    logic [4:0]  newCnt;
    logic [15:0] newRx;
    logic        isRes;
    logic [16:0] t1;
    logic [16:0] t4;
    logic [16:0] pmin;
    logic [16:0] pmax;

    // clamp a half period into the variant's legal range
    function automatic logic [15:0] clampHalf(input logic [15:0] a,
            input logic [16:0] lo, input logic [16:0] hi);
        logic [16:0] h;
        h = {a, 1'b0};
        if (h < lo) h = lo + 17'h00001;
        if (h > hi) h = hi;
        return h[16:1];
    endfunction

    // variant dependent timing counts
    always_comb begin
        t1   = slowVariant ? 17'(ssm_pkg::T1_SLOW) : 17'(ssm_pkg::T1_FAST);
        t4   = slowVariant ? 17'(ssm_pkg::T4_SLOW) : 17'(ssm_pkg::T4_FAST);
        pmin = slowVariant ? 17'(ssm_pkg::P_MIN_SLOW)
                           : 17'(ssm_pkg::P_MIN_FAST);
        pmax = slowVariant ? 17'(ssm_pkg::P_MAX_SLOW)
                           : 17'(MAX_PERIOD_FAST);
    end

    // next state of the whole sequencer
    always_comb begin
        n       = s;
        scrWe   = 1'b0;
        smpWe   = 1'b0;
        idxWe   = 1'b0;
        smpIn   = s.rxSh;
        pop     = 1'b0;
        push    = txValid && s.txReady;
        leading = (s.sclk == s.cpol);
        smpEdge = leading ^ s.cpha;
        newCnt  = s.bitCnt + {4'h0, smpEdge};
        newRx   = smpEdge ? {s.rxSh[14:0], s.miso2} : s.rxSh;
        isRes   = s.cur.op inside {ssm_pkg::OP_XFER, ssm_pkg::OP_BASIC,
                  ssm_pkg::OP_AUXP, ssm_pkg::OP_AUXL};
        n.done  = 1'b0;
        n.miso1 = misoI;
        n.miso2 = s.miso1;
        n.aux1  = auxIn;
        n.aux2  = s.aux1;
        n.rdData = sampleMem[8'(idxTbl[readIdx] + readOfs)];
        case (s.st)
            ssm_pkg::ST_IDLE: begin
                if (clearReq) begin
                    n.len = 7'h00;
                end else if (cmdValid && s.cmdReady) begin
                    scrWe = 1'b1;
                    n.len = s.len + 7'h01;
                end
                if (runReq && s.len != 7'h00 && !clearReq) begin
                    n.st       = ssm_pkg::ST_FETCH;
                    n.pc       = 7'h00;
                    n.busy     = 1'b1;
                    n.resCnt   = 7'h00;
                    n.smpPtr   = 8'h00;
                    n.overflow = 1'b0;
                end
            end
            ssm_pkg::ST_FETCH: begin
                if (s.pc == s.len) begin
                    n.st   = ssm_pkg::ST_IDLE;
                    n.busy = 1'b0;
                    n.done = 1'b1;
                end else begin
                    n.cur = scriptMem[s.pc[5:0]];
                    n.pc  = s.pc + 7'h01;
                    n.st  = ssm_pkg::ST_EXEC;
                end
            end
            ssm_pkg::ST_EXEC: begin
                n.st = ssm_pkg::ST_FETCH;
                if (isRes && s.resCnt == 7'(ssm_pkg::RES_MAX)) begin
                    n.overflow = 1'b1;
                end else begin
                    if (isRes) begin
                        idxWe    = 1'b1;
                        n.resCnt = s.resCnt + 7'h01;
                    end
                    case (s.cur.op)
                        ssm_pkg::OP_ENABLE: n.en = 1'b1;
                        ssm_pkg::OP_DISABLE: n.en = 1'b0;
                        ssm_pkg::OP_MODE: begin
                            n.cpol = s.cur.arg[1];
                            n.cpha = s.cur.arg[0];
                            n.sclk = s.cur.arg[1];
                        end
                        ssm_pkg::OP_RATE:
                            n.half = clampHalf(s.cur.arg, pmin, pmax);
                        ssm_pkg::OP_BITS: begin
                            if (s.cur.arg[4:0] == 5'h00
                                    || s.cur.arg[15:4] != 12'h000)
                                n.bits = 5'h10;
                            else
                                n.bits = s.cur.arg[4:0];
                        end
                        // explicit levels serve either select polarity
                        ssm_pkg::OP_CSLO:
                            n.cs[s.cur.arg[2:0]] = 1'b0;
                        ssm_pkg::OP_CSHI:
                            n.cs[s.cur.arg[2:0]] = 1'b1;
                        ssm_pkg::OP_XFER: begin
                            n.basic  = 1'b0;
                            n.remain = s.cur.arg[7:0];
                            if (s.cur.arg[7:0] != 8'h00)
                                n.st = ssm_pkg::ST_LOAD;
                        end
                        ssm_pkg::OP_BASIC: begin
                            n.basic  = 1'b1;
                            n.remain = s.cur.arg[7:0];
                            n.csSel  = s.cur.arg[10:8];
                            n.cs[s.cur.arg[10:8]] = 1'b0;
                            n.cnt    = t1;
                            n.st     = ssm_pkg::ST_LEAD;
                        end
                        ssm_pkg::OP_DELAY: begin
                            n.cnt = {1'b0, s.cur.arg};
                            n.st  = ssm_pkg::ST_WAIT;
                        end
                        ssm_pkg::OP_AUXP: begin
                            smpWe    = 1'b1;
                            smpIn    = {8'h00, s.aux2};
                            n.smpPtr = s.smpPtr + 8'h01;
                        end
                        ssm_pkg::OP_AUXL: begin
                            smpWe    = 1'b1;
                            smpIn    = {15'h0000, s.aux2[s.cur.arg[2:0]]};
                            n.smpPtr = s.smpPtr + 8'h01;
                        end
                        default: n.st = ssm_pkg::ST_FETCH;
                    endcase
                end
            end
            ssm_pkg::ST_LEAD: begin
                if (s.cnt > 17'h00001)
                    n.cnt = s.cnt - 17'h00001;
                else
                    n.st = (s.remain == 8'h00) ? ssm_pkg::ST_TRAIL
                                               : ssm_pkg::ST_LOAD;
                if (s.cnt <= 17'h00001 && s.remain == 8'h00)
                    n.cnt = t4;
            end
            ssm_pkg::ST_LOAD: begin
                if (s.bcnt != 2'h0) begin
                    pop      = 1'b1;
                    n.txSh   = s.buffer[s.rp] << (5'h10 - s.bits);
                    n.rxSh   = 16'h0000;
                    n.bitCnt = 5'h00;
                    n.cnt    = {1'b0, s.half};
                    n.st     = ssm_pkg::ST_SHIFT;
                    if (!s.cpha) begin
                        n.mosi = n.txSh[15];
                        n.txSh = n.txSh << 1;
                    end
                end
            end
            ssm_pkg::ST_SHIFT: begin
                if (s.cnt > 17'h00001) begin
                    n.cnt = s.cnt - 17'h00001;
                end else begin
                    n.cnt    = {1'b0, s.half};
                    n.sclk   = ~s.sclk;
                    n.rxSh   = newRx;
                    n.bitCnt = newCnt;
                    if (!smpEdge && !(!leading && newCnt == s.bits)) begin
                        n.mosi = s.txSh[15];
                        n.txSh = s.txSh << 1;
                    end
                    if (!leading && newCnt == s.bits) begin
                        smpWe    = 1'b1;
                        smpIn    = newRx;
                        n.smpPtr = s.smpPtr + 8'h01;
                        n.remain = s.remain - 8'h01;
                        if (s.remain != 8'h01)
                            n.st = ssm_pkg::ST_LOAD;
                        else if (s.basic) begin
                            n.cnt = t4;
                            n.st  = ssm_pkg::ST_TRAIL;
                        end else
                            n.st = ssm_pkg::ST_FETCH;
                    end
                end
            end
            ssm_pkg::ST_TRAIL: begin
                if (s.cnt > 17'h00001) begin
                    n.cnt = s.cnt - 17'h00001;
                end else begin
                    n.cs[s.csSel] = 1'b1;
                    n.st = ssm_pkg::ST_FETCH;
                end
            end
            ssm_pkg::ST_WAIT: begin
                if (s.cnt > 17'h00001)
                    n.cnt = s.cnt - 17'h00001;
                else
                    n.st = ssm_pkg::ST_FETCH;
            end
            default: n.st = ssm_pkg::ST_IDLE;
        endcase
        // two entry transmit buffer, stalls the source when full
        if (push) begin
            n.buffer[s.wp] = txData;
            n.wp = ~s.wp;
        end
        if (pop) n.rp = ~s.rp;
        n.bcnt     = s.bcnt + {1'b0, push} - {1'b0, pop};
        n.txReady  = (n.bcnt != 2'h2);
        n.cmdReady = (n.st == ssm_pkg::ST_IDLE)
                     && (n.len != 7'(ssm_pkg::SCR_DEPTH));
    end

    // state register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s      <= '0;
            s.half <= ssm_pkg::HALF_RST;
            s.bits <= ssm_pkg::BITS_RST;
            s.cs   <= 8'hFF;
        end else begin
            s <= n;
        end
    end

    // script, sample and index memories, no reset needed
    always_ff @(posedge core_clk) begin
        if (scrWe) scriptMem[s.len[5:0]] <= cmdData;
        if (smpWe) sampleMem[s.smpPtr] <= smpIn;
        if (idxWe) idxTbl[s.resCnt[5:0]] <= s.smpPtr;
    end

    // outputs straight from the state register
    assign cmdReady = s.cmdReady;
    assign busy     = s.busy;
    assign done     = s.done;
    assign overflow = s.overflow;
    assign resCount = s.resCnt;
    assign txReady  = s.txReady;
    assign rdData   = s.rdData;
    assign sclkO    = s.sclk;
    assign mosiO    = s.mosi;
    assign csO      = s.cs;
    assign sclkOe   = s.en;
    assign mosiOe   = s.en;
    assign csOe     = s.en;

    // helper: cycles spent in the current lead or trail wait
    logic [16:0] waitLen;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn)
            waitLen <= 17'h00000;
        else if (s.st == n.st)
            waitLen <= waitLen + 17'h00001;
        else
            waitLen <= 17'h00000;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_enable_drive: assert property (s.st == ssm_pkg::ST_EXEC
        && s.cur.op == ssm_pkg::OP_ENABLE && s.resCnt <= 7'h40
        |=> sclkOe && mosiOe && csOe) else $error("enable not driven");
    a_disable_tri: assert property (s.st == ssm_pkg::ST_EXEC
        && s.cur.op == ssm_pkg::OP_DISABLE
        |=> !sclkOe && !mosiOe && !csOe) else $error("disable left pins on");
    a_mode_set: assert property (s.st == ssm_pkg::ST_EXEC
        && s.cur.op == ssm_pkg::OP_MODE
        |=> sclkO == $past(s.cur.arg[1]) && s.cpha == $past(s.cur.arg[0]))
        else $error("mode not applied");
    a_rate_edge: assert property (s.st == ssm_pkg::ST_SHIFT
        && s.cnt > 17'h00001 |=> $stable(sclkO))
        else $error("clock edge before half period");
    a_cs_low: assert property (s.st == ssm_pkg::ST_EXEC
        && s.cur.op == ssm_pkg::OP_CSLO
        |=> !csO[$past(s.cur.arg[2:0])]) else $error("select not low");
    a_cs_high: assert property (s.st == ssm_pkg::ST_EXEC
        && s.cur.op == ssm_pkg::OP_CSHI
        |=> csO[$past(s.cur.arg[2:0])]) else $error("select not high");
    a_result_limit: assert property (s.resCnt <= 7'h40)
        else $error("too many result commands");
    a_fetch_order: assert property (s.st == ssm_pkg::ST_FETCH
        && s.pc != s.len |=> s.pc == $past(s.pc) + 7'h01)
        else $error("script order broken");
    a_lead_wait: assert property (s.st == ssm_pkg::ST_LEAD
        && n.st != ssm_pkg::ST_LEAD |-> waitLen + 17'h00001 >= t1)
        else $error("lead wait too short");
    a_trail_wait: assert property (s.st == ssm_pkg::ST_TRAIL
        && n.st != ssm_pkg::ST_TRAIL && s.basic
        |-> waitLen + 17'h00001 >= t4) else $error("trail wait too short");
endmodule
`default_nettype wire

/* verif/ssm_sequencer_bench.sv */
// Purpose: self-checking bench of the scripted spi master sequencer
// Assumes: slave model on select 0, clock half period of 4 cycles
// Notes:   each scenario loads a script, runs it, judges results
`timescale 1ns/1ps
`default_nettype none
module ssm_sequencer_bench;
    logic        core_clk, resetn, slowVariant, cmdValid, cmdReady;
    logic        clearReq, runReq, busy, done, overflow, txValid, txReady;
    logic        sclkO, sclkOe, mosiO, mosiOe, misoI, csOe, cpol, cpha;
    logic        pSclk, pCs1;
    logic [6:0]  resCount;
    logic [15:0] txData, rdData, pattern;
    logic [5:0]  readIdx;
    logic [7:0]  readOfs, csO, auxIn;
    logic [31:0] rxBits;
    int          rxCount, bad_count, n_compared, cyc, tFall, tFirst;
    int          tLast, tRise, gap;
    ssm_pkg::ssm_cmd_type cmdData;

    ssm_sequencer u_dut (.core_clk, .resetn, .slowVariant, .cmdValid,
        .cmdData, .cmdReady, .clearReq, .runReq, .busy, .done, .overflow,
        .resCount, .txValid, .txData, .txReady, .readIdx, .readOfs, .rdData,
        .sclkO, .sclkOe, .mosiO, .mosiOe, .misoI, .csO, .csOe, .auxIn);
    ssm_slave_model u_slave (.sclk(sclkO), .mosi(mosiO),
        .selectN(~(csOe & ~csO[0])), .cpol, .cpha, .pattern,
        .miso(misoI), .rxBits, .rxCount);

    // 100 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // cycle stamps of select and clock edges, plus the hang limit
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (sclkO != pSclk) begin
            gap = cyc - tLast;
            tLast = cyc;
            if (tFirst < tFall) tFirst = cyc;
        end
        if (pCs1 && !csO[1]) tFall = cyc;
        if (!pCs1 && csO[1]) tRise = cyc;
        pSclk = sclkO;
        pCs1 = csO[1];
        if (cyc > 20000) begin
            bad_count++;
            report_and_stop;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic put(input ssm_pkg::ssm_op_type op,
                       input logic [15:0] arg);
        @(negedge core_clk);
        while (cmdReady !== 1'b1) @(negedge core_clk);
        cmdValid = 1'b1;
        cmdData.op = op;
        cmdData.arg = arg;
        @(negedge core_clk);
        cmdValid = 1'b0;
    endtask
    task automatic push(input logic [15:0] d);
        @(negedge core_clk);
        while (txReady !== 1'b1) @(negedge core_clk);
        txValid = 1'b1;
        txData = d;
        @(negedge core_clk);
        txValid = 1'b0;
    endtask
    task automatic clear_script;
        @(negedge core_clk);
        clearReq = 1'b1;
        @(negedge core_clk);
        clearReq = 1'b0;
    endtask
    task automatic run_script;
        @(negedge core_clk);
        runReq = 1'b1;
        @(negedge core_clk);
        runReq = 1'b0;
        check(busy, 1, "busy after run");
        repeat (5000) begin
            @(negedge core_clk);
            if (done === 1'b1) break;
        end
        check(done, 1, "done pulse");
        check(busy, 0, "busy after done");
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] o);
        readIdx = i;
        readOfs = o;
        @(negedge core_clk);
    endtask

    // two bytes in mode 0 on select 0, buffer filled first
    task automatic t_exchange;
        pattern = 16'h5A5A;
        clear_script;
        push(16'h00C3);
        push(16'h0081);
        check(txReady, 0, "buffer full");
        put(ssm_pkg::OP_ENABLE, 16'h0000);
        put(ssm_pkg::OP_MODE, 16'h0000);
        put(ssm_pkg::OP_RATE, 16'h0004);
        put(ssm_pkg::OP_BITS, 16'h0008);
        put(ssm_pkg::OP_CSLO, 16'h0000);
        put(ssm_pkg::OP_XFER, 16'h0002);
        put(ssm_pkg::OP_CSHI, 16'h0000);
        repeat (10) @(negedge core_clk);
        check({busy, csOe}, 0, "idle before run");
        run_script;
        check(rxBits[15:0], 16'hC381, "slave rx");
        check(rxCount, 16, "slave bit count");
        check(gap, 4, "clock half period");
        check({csO[0], csOe, sclkOe, mosiOe}, 4'hF, "pins");
        rd(6'h00, 8'h00);
        check(rdData[7:0], 8'h5A, "result 0 word 0");
        rd(6'h00, 8'h01);
        check(rdData[7:0], 8'h5A, "result 0 word 1");
        check(resCount, 1, "result count");
    endtask
    // mode 3 with four bit samples
    task automatic t_mode3;
        pattern = 16'h9999;
        cpol = 1'b1;
        cpha = 1'b1;
        clear_script;
        push(16'h0006);
        put(ssm_pkg::OP_MODE, 16'h0003);
        put(ssm_pkg::OP_BITS, 16'h0004);
        put(ssm_pkg::OP_CSLO, 16'h0000);
        put(ssm_pkg::OP_XFER, 16'h0001);
        put(ssm_pkg::OP_CSHI, 16'h0000);
        run_script;
        check(sclkO, 1, "idle clock level");
        check(rxCount, 4, "slave bit count");
        check(rxBits[3:0], 4'h6, "slave rx");
        rd(6'h00, 8'h00);
        check(rdData[3:0], 4'h9, "mode 3 result");
    endtask
    // aux port reads around an exchange inside one frame
    task automatic t_aux;
        int c0;
        auxIn = 8'h3C;
        clear_script;
        push(16'h0001);
        put(ssm_pkg::OP_CSLO, 16'h0000);
        put(ssm_pkg::OP_AUXP, 16'h0000);
        put(ssm_pkg::OP_XFER, 16'h0001);
        put(ssm_pkg::OP_DELAY, 16'h012C);
        put(ssm_pkg::OP_AUXP, 16'h0000);
        put(ssm_pkg::OP_CSHI, 16'h0000);
        put(ssm_pkg::OP_DISABLE, 16'h0000);
        c0 = cyc;
        run_script;
        check(cyc - c0 >= 300, 1, "delay held");
        rd(6'h00, 8'h00);
        check(rdData[7:0], 8'h3C, "aux read first");
        rd(6'h02, 8'h00);
        check(rdData[7:0], 8'h3C, "aux read third");
        check(resCount, 3, "result count");
        check({sclkOe, mosiOe, csOe}, 0, "pins released");
    endtask
    // basic transfer on select 1 in both variants, waits and clamp
    task automatic t_basic;
        int lead;
        int trail;
        for (int v = 0; v < 2; v++) begin
            slowVariant = v[0];
            lead = v ? ssm_pkg::T1_SLOW : ssm_pkg::T1_FAST;
            trail = v ? ssm_pkg::T4_SLOW : ssm_pkg::T4_FAST;
            clear_script;
            push(16'h00A5);
            put(ssm_pkg::OP_ENABLE, 16'h0000);
            if (v == 1)
                put(ssm_pkg::OP_RATE, 16'h0001);
            put(ssm_pkg::OP_BASIC, 16'h0101);
            put(ssm_pkg::OP_DISABLE, 16'h0000);
            run_script;
            check(tFirst - tFall >= lead, 1, "lead wait");
            check(tRise - tLast >= trail, 1, "trail wait");
            if (v == 1)
                check(gap, (ssm_pkg::P_MIN_SLOW + 1) / 2, "clamp");
        end
        slowVariant = 1'b0;
    endtask
    // a full script of result commands
    task automatic t_limit;
        clear_script;
        repeat (64) put(ssm_pkg::OP_AUXL, 16'h0003);
        @(negedge core_clk);
        check(cmdReady, 0, "script full");
        run_script;
        check({overflow, resCount}, 8'h40, "64 results kept");
        rd(6'h3F, 8'h00);
        check(rdData, 16'h0001, "last line read");
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // reset, then every scenario in turn
    initial begin
        {resetn, slowVariant, cmdValid, clearReq, runReq, txValid} = 6'h00;
        {cpol, cpha, pSclk, pCs1} = 4'h1;
        cmdData = '0;
        txData = 16'h0000;
        {readIdx, readOfs, auxIn} = 22'h000000;
        pattern = 16'h0000;
        {bad_count, n_compared, cyc, tFall, tFirst, tLast, tRise} = '0;
        gap = 0;
        repeat (6) @(negedge core_clk);
        check({csO, csOe, sclkOe, mosiOe}, 11'h7F8, "reset pins");
        resetn = 1'b1;
        repeat (2) @(negedge core_clk);
        t_exchange;
        t_mode3;
        t_aux;
        t_basic;
        t_limit;
        report_and_stop;
    end
endmodule
`default_nettype wire

/* verif/ssm_slave_model.sv */
// Purpose: behavioural spi slave that answers a repeating pattern
// Assumes: selectN low selects it, clock mode given by the bench
// Notes:   a released miso shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none
module ssm_slave_model (
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic        selectN,
    input  wire logic        cpol,
    input  wire logic        cpha,
    input  wire logic [15:0] pattern,
    output logic             miso,
    output logic [31:0]      rxBits,
    output int               rxCount
);
    logic [15:0] sh;
    // frame start reloads the reply, release inverts the line
    always @(selectN) begin
        if (!selectN) begin
            sh = pattern;
            rxCount = 0;
            if (!cpha) begin
                miso = sh[15];
                sh = {sh[14:0], sh[15]};
            end
        end else begin
            miso = ~miso;
        end
    end
    // sample on one edge, launch on the other
    always @(sclk) begin
        if (!selectN) begin
            if ((sclk != cpol) ^ cpha) begin
                rxBits = {rxBits[30:0], mosi};
                rxCount = rxCount + 1;
            end else begin
                miso = sh[15];
                sh = {sh[14:0], sh[15]};
            end
        end
    end
endmodule
`default_nettype wire
